//--- boundary_scan_instruction_control_test.sv
// boundary_scan_instruction_control_test: both link ends driven from their user sides
// assumes: package, link interface, both ends and the monitor compiled first
`default_nettype none
module boundary_scan_instruction_control_test import bsic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ICYC = 20; // short init window
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h1; // lowered at 2 ns so every async flop sees an edge
	logic scan_used = 1'h1, cfg_done = 1'h0, hold_init = 1'h1; // device and host levels
	logic bit_req = 1'h0, tms_b = 1'h1, tdi_b = 1'h0; // host request
	logic [BS_W-1:0] pin_v = 8'h00, sys_v = 8'h00, io_o, core_o;
	logic [IR_W-1:0] instr_o;
	logic pins_user, bit_done, tdo_b, init_high;
	logic cfg_start; // device saw the init wire high
	logic [31:0] rng = 32'h9571c012; // xorshift state
	int failures = 0, checks = 0;
	bsic_link_if u_bsic_link_if ();
	// open-drain init wire with pull-up
	assign u_bsic_link_if.init_in = !(u_bsic_link_if.init_dev_oe || u_bsic_link_if.init_host_oe);
	always #10 clk_in = ~clk_in;
	bsic_device #(.INIT_CYC(ICYC), .HOLD_VARIANT(1'h0)) u_bsic_device (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .link(u_bsic_link_if), .scan_used_in(scan_used),
		.config_done_in(cfg_done), .pin_in_in(pin_v), .sys_out_in(sys_v), .io_out_out(io_o),
		.core_in_out(core_o), .test_pins_user_out(pins_user), .config_start_out(cfg_start),
		.instr_out(instr_o));
	bsic_host u_bsic_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(u_bsic_link_if),
		.bit_req_in(bit_req), .tms_bit_in(tms_b), .tdi_bit_in(tdi_b), .hold_init_in(hold_init),
		.bit_done_out(bit_done), .tdo_bit_out(tdo_b), .busy_out(), .init_high_out(init_high));
	bsic_link_monitor #(.INIT_CYC(ICYC)) u_bsic_link_monitor (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .tck(u_bsic_link_if.tck), .tms(u_bsic_link_if.tms),
		.tdi(u_bsic_link_if.tdi), .tdo(u_bsic_link_if.tdo), .tdo_oe(u_bsic_link_if.tdo_oe),
		.init_dev_oe(u_bsic_link_if.init_dev_oe));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one tck cycle through the host, bounded wait on its done pulse
	task automatic step(input logic m, input logic d, output logic o);
		int n = 0;
		@(posedge clk_in);
		#2;
		bit_req = 1'h1;
		tms_b = m;
		tdi_b = d;
		@(posedge clk_in);
		#2;
		bit_req = 1'h0;
		while (bit_done !== 1'h1 && n < 20) begin
			@(posedge clk_in);
			#2;
			n++;
		end
		if (n == 20) begin
			failures++;
			wrap_up();
		end
		o = tdo_b;
	endtask : step
	// idle to shift, n bits lsb first, update, back to idle
	task automatic xfer(input logic ir, input int n, input logic [7:0] din, output logic [7:0] q);
		logic o;
		q = 8'h00;
		step(1'h1, 1'h0, o);
		if (ir) step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			q[i] = o;
		end
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o); // one idle tck so registered outputs follow the update
	endtask : xfer
	// instruction load and its status word
	task automatic load(input logic [2:0] code, input logic flag);
		logic [7:0] q;
		xfer(1'h1, IR_W, {5'h00, code}, q);
		chk("status", {5'h00, flag, IR_CAPT_FIX[1:0]}, q);
	endtask : load
	initial begin
		logic [7:0] q;
		logic o;
		logic [2:0] byp [4] = '{OP_BYPASS, OP_USER_INSTR_ONE, OP_USER_INSTR_TWO, OP_RSVD};
		logic [2:0] all [6] = '{OP_EXTEST, OP_SAMPLE, OP_USER_INSTR_ONE, OP_USER_INSTR_TWO, OP_RDBACK, OP_BYPASS};
		#2;
		reset_n_in = 1'h0;
		repeat (16) @(posedge clk_in);
		#2;
		reset_n_in = 1'h1;
		rng = xs(rng);
		pin_v = rng[7:0];
		sys_v = rng[15:8];
		step(1'h0, 1'h0, o);
		// pre-config, init held low by the controller
		load(OP_SAMPLE, 1'h1);
		xfer(1'h0, BS_W, {rng[23:17], 1'h0}, q);
		chk("capture", pin_v ^ sys_v, q);
		chk("sample io", sys_v, io_o);
		chk("sample core", pin_v, core_o);
		load(OP_EXTEST, 1'h1);
		chk("extest io", {rng[23:17], 1'h0}, io_o);
		chk("extest core", {rng[23:17], 1'h0}, core_o);
		xfer(1'h0, BS_W, {rng[31:25], 1'h0}, q);
		chk("extest shift", pin_v ^ sys_v, q);
		chk("update", {rng[31:25], 1'h0}, io_o);
		xfer(1'h0, BS_W, {rng[31:25], 1'h1}, q);
		chk("init cell", sys_v, io_o);
		foreach (byp[i]) begin
			load(byp[i], 1'h1);
			rng = xs(rng);
			xfer(1'h0, BS_W, rng[7:0], q);
			chk("bypass", {rng[6:0], 1'h0}, q);
		end
		$display("test pre-config done");
		chk("config held", 8'h00, {7'h00, cfg_start});
		// release init, configuration under way
		hold_init = 1'h0;
		for (int i = 0; i < 200 && init_high !== 1'h1; i++) @(posedge clk_in);
		#2;
		chk("init high", 8'h01, {7'h00, init_high});
		chk("config start", 8'h01, {7'h00, cfg_start});
		if (init_high !== 1'h1) wrap_up();
		load(OP_EXTEST, 1'h0);
		chk("refused", 8'(OP_BYPASS), 8'(instr_o));
		load(OP_SAMPLE, 1'h0);
		chk("reduced", 8'(OP_SAMPLE), 8'(instr_o));
		$display("test mid-config done");
		// configured with scan in the design
		cfg_done = 1'h1;
		foreach (all[i]) begin
			load(all[i], 1'h1);
			chk("instr", 8'(all[i]), 8'(instr_o));
		end
		chk("pins kept", 8'h00, {7'h00, pins_user});
		$display("test post-config done");
		// fresh power-up of a design without the scan primitive
		reset_n_in = 1'h0;
		scan_used = 1'h0;
		repeat (4) @(posedge clk_in);
		#2;
		reset_n_in = 1'h1;
		repeat (4) @(posedge clk_in);
		#2;
		chk("pins user", 8'h01, {7'h00, pins_user});
		$display("test no scan done");
		wrap_up();
	end
endmodule : boundary_scan_instruction_control_test
`default_nettype wire

//--- bsic_device.sv
// bsic_device: test access port of the programmable device, on the test clock
// assumes: link.tck from the controller; clk_in times the init release, config start and test-pin handover
`default_nettype none
// How it works
// - full scan access before configuration starts; here readback loads as bypass until after config
// - post-config scan only if design includes it
// - controller loads only sample, bypass, reserved or user codes mid-config
// - reserved and user codes always accepted
// - extest and configure only while init low or after config
// - init released about 1 ms, extendable
// - init cell in chain; variant A drops extest substitution while it is set before config
// - variant B holds init low under extest
// - instruction load returns availability flag
// - unconfigured scan logic answers any pins
// - no scan primitive frees test pins
// - seven instructions implemented
// - extest substitutes latch for io values
// - capture loads pins and internal drivers
// - shift-dr shifts out while shifting in
// - update-dr copies shift register into latch
// - extest substitution starts at load; here one tck after update-ir
// - last dr operation before extest must be valid
// - extest tests internal logic; controller masks
// - sample behaves like extest, io unchanged
// - bypass is one-bit shift stage
// - controller holds init low to finish scan first
module bsic_device
	import bsic_pkg::*;
#(
	parameter int INIT_CYC = INIT_REL_CYC, // shorten in simulation
	parameter bit HOLD_VARIANT = 1'b0 // 1: extest keeps init low
) (
	input wire logic clk_in,
	input wire logic reset_n_in, // power-up reset
	bsic_link_if.device link,
	input wire logic scan_used_in, // design includes scan_primitive
	input wire logic config_done_in, // start-up sequence finished
	input wire logic [BS_W-1:0] pin_in_in, // values on input pins
	input wire logic [BS_W-1:0] sys_out_in, // system logic output drive
	output logic [BS_W-1:0] io_out_out, // data toward io_block
	output logic [BS_W-1:0] core_in_out, // data toward internal logic
	output logic test_pins_user_out, // test pins free as io_block
	output logic config_start_out, // configuration kicked off
	output logic [IR_W-1:0] instr_out // active instruction
);
	// power-up release timer on clk_in
	logic [31:0] rel_cnt_r;
	logic rel_done_r;
	logic init_s1_r, init_s2_r; // init wire into clk_in domain
	logic hold_t_r, hold_s1_r, hold_s2_r; // extest hold, tck to clk
	logic done_s1_r, done_s2_r; // config done into tck domain
	logic used_s1_r, used_s2_r;
	logic initk_s1_r, initk_s2_r; // init wire into tck domain
	logic pdone_s1_r, pdone_s2_r; // config done into clk_in domain
	logic pused_s1_r, pused_s2_r; // scan used into clk_in domain
	bsic_tap_t tap_r;
	logic [IR_W-1:0] ir_sh_r, ir_r;
	logic [BS_W-1:0] bs_sh_r, bs_up_r;
	logic byp_r;
	logic tdo_r, tdo_oe_r;
	logic scan_on;
	bsic_phase_t phase;

	// count out the release delay after power-up
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rel_cnt_r <= 32'h0;
			rel_done_r <= 1'b0;
		end else if (rel_cnt_r >= 32'(INIT_CYC - 1)) begin
			rel_done_r <= 1'b1;
		end else begin
			rel_cnt_r <= rel_cnt_r + 32'h1;
		end
	end

	// bring init level and extest hold into clk_in
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			init_s1_r <= 1'b0;
			init_s2_r <= 1'b0;
			hold_s1_r <= 1'b0;
			hold_s2_r <= 1'b0;
		end else begin
			init_s1_r <= link.init_in;
			init_s2_r <= init_s1_r;
			hold_s1_r <= hold_t_r;
			hold_s2_r <= hold_s1_r;
		end
	end

	// open-drain init: pull low until released and not held by extest
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link.init_dev_oe <= 1'b1;
			config_start_out <= 1'b0;
		end else begin
			link.init_dev_oe <= !rel_done_r || hold_s2_r;
			config_start_out <= init_s2_r; // external low extends the window
		end
	end

	// status levels into the tck domain
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			used_s1_r <= 1'b0;
			used_s2_r <= 1'b0;
			initk_s1_r <= 1'b0;
			initk_s2_r <= 1'b0;
		end else begin
			done_s1_r <= config_done_in;
			done_s2_r <= done_s1_r;
			used_s1_r <= scan_used_in;
			used_s2_r <= used_s1_r;
			initk_s1_r <= link.init_in;
			initk_s2_r <= initk_s1_r;
		end
	end

	// period of operation, and whether scan logic responds at all
	always_comb begin
		if (!initk_s2_r) phase = PH_PRE;
		else if (!done_s2_r) phase = PH_INTER;
		else phase = PH_POST;
		scan_on = (phase != PH_POST) || used_s2_r;
	end

	// port pins go to user logic when the scan primitive is absent
	// own synchronisers: tck may be parked, and tck flops must not feed clk_in logic
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pdone_s1_r <= 1'b0;
			pdone_s2_r <= 1'b0;
			pused_s1_r <= 1'b0;
			pused_s2_r <= 1'b0;
			test_pins_user_out <= 1'b0;
		end else begin
			pdone_s1_r <= config_done_in;
			pdone_s2_r <= pdone_s1_r;
			pused_s1_r <= scan_used_in;
			pused_s2_r <= pused_s1_r;
			test_pins_user_out <= pdone_s2_r && !pused_s2_r;
		end
	end

	// test access state machine on tms
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) tap_r <= ST_RESET;
		else if (!scan_on) tap_r <= ST_RESET;
		else begin
			case (tap_r)
				ST_RESET: tap_r <= link.tms ? ST_RESET : ST_IDLE;
				ST_IDLE: tap_r <= link.tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: tap_r <= link.tms ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: tap_r <= link.tms ? ST_EX1_DR : ST_SH_DR;
				ST_SH_DR: tap_r <= link.tms ? ST_EX1_DR : ST_SH_DR;
				ST_EX1_DR: tap_r <= link.tms ? ST_UPD_DR : ST_PA_DR;
				ST_PA_DR: tap_r <= link.tms ? ST_EX2_DR : ST_PA_DR;
				ST_EX2_DR: tap_r <= link.tms ? ST_UPD_DR : ST_SH_DR;
				ST_UPD_DR: tap_r <= link.tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: tap_r <= link.tms ? ST_RESET : ST_CAP_IR;
				ST_CAP_IR: tap_r <= link.tms ? ST_EX1_IR : ST_SH_IR;
				ST_SH_IR: tap_r <= link.tms ? ST_EX1_IR : ST_SH_IR;
				ST_EX1_IR: tap_r <= link.tms ? ST_UPD_IR : ST_PA_IR;
				ST_PA_IR: tap_r <= link.tms ? ST_EX2_IR : ST_PA_IR;
				ST_EX2_IR: tap_r <= link.tms ? ST_UPD_IR : ST_SH_IR;
				ST_UPD_IR: tap_r <= link.tms ? ST_SEL_DR : ST_IDLE;
				default: tap_r <= ST_RESET;
			endcase
		end
	end

	// instruction shift and update; status word carries availability
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ir_sh_r <= OP_BYPASS;
			ir_r <= OP_BYPASS;
		end else if (tap_r == ST_RESET) begin
			ir_r <= OP_BYPASS;
		end else if (tap_r == ST_CAP_IR) begin
			// flag high when extest and configure are usable (outside the config window)
			ir_sh_r <= {phase != PH_INTER, IR_CAPT_FIX[1:0]};
		end else if (tap_r == ST_SH_IR) begin
			ir_sh_r <= {link.tdi, ir_sh_r[IR_W-1:1]};
		end else if (tap_r == ST_UPD_IR) begin
			case (ir_sh_r)
				OP_EXTEST, OP_CONFIG: // only before init rises or after config
					ir_r <= (phase == PH_INTER) ? OP_BYPASS : ir_sh_r;
				OP_RDBACK:
					ir_r <= (phase == PH_POST) ? ir_sh_r : OP_BYPASS;
				OP_RSVD, OP_USER_INSTR_ONE, OP_USER_INSTR_TWO, OP_SAMPLE, OP_BYPASS:
					ir_r <= ir_sh_r; // always accepted
				default: ir_r <= OP_BYPASS;
			endcase
		end
	end

	// boundary register: capture, shift, update (bypass also disturbs it)
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bs_sh_r <= '0;
			byp_r <= 1'b0;
		end else if (tap_r == ST_CAP_DR) begin
			// pins, with internal drive overlaid on outputs
			bs_sh_r <= pin_in_in ^ sys_out_in;
			byp_r <= 1'b0;
		end else if (tap_r == ST_SH_DR) begin
			bs_sh_r <= {link.tdi, bs_sh_r[BS_W-1:1]};
			byp_r <= link.tdi; // single stage
		end
	end

	// update latch written on every update-dr
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) bs_up_r <= '0;
		else if (tap_r == ST_UPD_DR) bs_up_r <= bs_sh_r;
	end

	// extest before config: variant b holds init low while extest is loaded
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) hold_t_r <= 1'b0;
		else hold_t_r <= HOLD_VARIANT && (ir_r == OP_EXTEST) && phase == PH_PRE;
	end

	// substitution on io and core outputs, one tck after the extest load
	always_ff @(posedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			io_out_out <= '0;
			core_in_out <= '0;
			instr_out <= OP_BYPASS;
		end else begin
			instr_out <= ir_r;
			if (ir_r == OP_EXTEST &&
				!(!HOLD_VARIANT && phase == PH_PRE && bs_up_r[INIT_BIT])) begin
				io_out_out <= bs_up_r;
				core_in_out <= bs_up_r;
			end else begin
				io_out_out <= sys_out_in;
				core_in_out <= pin_in_in;
			end
		end
	end

	// serial output on the falling edge, enabled only in shift states
	always_ff @(negedge link.tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tdo_oe_r <= (tap_r == ST_SH_DR) || (tap_r == ST_SH_IR);
			if (tap_r == ST_SH_IR) tdo_r <= ir_sh_r[0];
			else if (ir_r == OP_EXTEST || ir_r == OP_SAMPLE) tdo_r <= bs_sh_r[0];
			else tdo_r <= byp_r; // bypass, and unbacked user codes
		end
	end

	assign link.tdo = tdo_r;
	assign link.tdo_oe = tdo_oe_r;
endmodule : bsic_device
`default_nettype wire

//--- bsic_host.sv
// bsic_host: test controller end; makes tck by dividing clk_in, runs one tck cycle per request
// assumes: user side gives a shift request with tms/tdi bit pair per tck cycle
`default_nettype none
module bsic_host
	import bsic_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	bsic_link_if.host link,
	input wire logic bit_req_in, // pulse: send one tck cycle
	input wire logic tms_bit_in,
	input wire logic tdi_bit_in,
	input wire logic hold_init_in, // keep device in pre-config window
	output logic bit_done_out, // pulse: tdo sample valid
	output logic tdo_bit_out,
	output logic busy_out,
	output logic init_high_out // init wire seen high
);
	bsic_host_t st_r;
	logic [7:0] div_r;
	logic tck_r, tms_r, tdi_r;
	logic i1_r, i2_r;

	// one tck cycle per request: low half, then high half
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= HS_IDLE;
			div_r <= 8'h0;
			tck_r <= 1'b0;
			tms_r <= 1'b1;
			tdi_r <= 1'b0;
			bit_done_out <= 1'b0;
			tdo_bit_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			bit_done_out <= 1'b0;
			case (st_r)
				HS_IDLE: if (bit_req_in) begin
					tms_r <= tms_bit_in; // changes while tck low
					tdi_r <= tdi_bit_in;
					div_r <= 8'h0;
					busy_out <= 1'b1;
					st_r <= HS_LOW;
				end
				HS_LOW: if (div_r == 8'(TCK_DIV - 1)) begin
					tck_r <= 1'b1;
					tdo_bit_out <= link.tdo; // stable since falling edge
					div_r <= 8'h0;
					st_r <= HS_HIGH;
				end else div_r <= div_r + 8'h1;
				HS_HIGH: if (div_r == 8'(TCK_DIV - 1)) begin
					tck_r <= 1'b0;
					st_r <= HS_DONE;
				end else div_r <= div_r + 8'h1;
				HS_DONE: begin
					bit_done_out <= 1'b1;
					busy_out <= 1'b0;
					st_r <= HS_IDLE;
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	// hold init low to finish scan work before configuration
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link.init_host_oe <= 1'b0;
			i1_r <= 1'b0;
			i2_r <= 1'b0;
			init_high_out <= 1'b0;
		end else begin
			link.init_host_oe <= hold_init_in;
			i1_r <= link.init_in;
			i2_r <= i1_r;
			init_high_out <= i2_r;
		end
	end

	assign link.tck = tck_r;
	assign link.tms = tms_r;
	assign link.tdi = tdi_r;
endmodule : bsic_host
`default_nettype wire

//--- bsic_link_if.sv
// bsic_link_if: the four-wire test access link plus the open-drain init pin
// assumes: the bench resolves the init wire from the enables and the pull-up
`default_nettype none
interface bsic_link_if;
	logic tck; // test clock, made by the controller end
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe; // high while the device drives tdo
	logic init_in; // resolved level of the init wire
	logic init_dev_oe; // device pulls init low
	logic init_host_oe; // controller pulls init low
	modport device (input tck, input tms, input tdi, output tdo, output tdo_oe,
		input init_in, output init_dev_oe);
	modport host (output tck, output tms, output tdi, input tdo, input tdo_oe,
		input init_in, output init_host_oe);
endinterface : bsic_link_if
`default_nettype wire

//--- bsic_link_monitor.sv
// bsic_link_monitor: assertions on the test access link between both ends
// assumes: placed beside the link interface; one reset serves both clocks
`default_nettype none
module bsic_link_monitor
	import bsic_pkg::*;
#(
	parameter int INIT_CYC = 20 // init release count in clk cycles
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic init_dev_oe
);
	bsic_tap_t st_r; // mirrored controller state
	int sh_r; // bits shifted since entering shift-ir
	int cyc_r; // clk cycles since reset, saturating
	// mirror of the controller state, stepped on tck
	always_ff @(posedge tck or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= ST_RESET;
		end else begin
			case (st_r)
				ST_RESET: st_r <= tms ? ST_RESET : ST_IDLE;
				ST_IDLE, ST_UPD_DR, ST_UPD_IR: st_r <= tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: st_r <= tms ? ST_SEL_IR : ST_CAP_DR;
				ST_SEL_IR: st_r <= tms ? ST_RESET : ST_CAP_IR;
				ST_CAP_DR, ST_SH_DR: st_r <= tms ? ST_EX1_DR : ST_SH_DR;
				ST_CAP_IR, ST_SH_IR: st_r <= tms ? ST_EX1_IR : ST_SH_IR;
				ST_EX1_DR: st_r <= tms ? ST_UPD_DR : ST_PA_DR;
				ST_EX1_IR: st_r <= tms ? ST_UPD_IR : ST_PA_IR;
				ST_PA_DR: st_r <= tms ? ST_EX2_DR : ST_PA_DR;
				ST_PA_IR: st_r <= tms ? ST_EX2_IR : ST_PA_IR;
				ST_EX2_DR: st_r <= tms ? ST_UPD_DR : ST_SH_DR;
				default: st_r <= tms ? ST_UPD_IR : ST_SH_IR;
			endcase
		end
	end
	// position within the status word
	always_ff @(posedge tck or negedge reset_n_in) begin
		if (!reset_n_in) sh_r <= 0;
		else sh_r <= (st_r == ST_SH_IR) ? sh_r + 1 : 0;
	end
	// time since power-up, for the init window
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) cyc_r <= 0;
		else if (cyc_r < INIT_CYC + 8) cyc_r <= cyc_r + 1;
	end
	tdo_enable_a: assert property (@(posedge tck) disable iff (!reset_n_in)
		tdo_oe == (st_r == ST_SH_IR || st_r == ST_SH_DR)) else $error("tdo enable off state");
	tdo_edge_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved while tck high");
	ir_status0_a: assert property (@(posedge tck) disable iff (!reset_n_in)
		st_r == ST_SH_IR && sh_r == 0 |-> tdo == IR_CAPT_FIX[0]) else $error("status bit0");
	ir_status1_a: assert property (@(posedge tck) disable iff (!reset_n_in)
		st_r == ST_SH_IR && sh_r == 1 |-> tdo == IR_CAPT_FIX[1]) else $error("status bit1");
	init_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		cyc_r < INIT_CYC - 4 |-> init_dev_oe) else $error("init released early");
	init_release_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		cyc_r == INIT_CYC + 6 |-> !init_dev_oe) else $error("init not released");
	tck_high_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(tck) |=> tck ##1 !tck) else $error("tck high phase");
	tck_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$fell(tck) |-> !tck [*3]) else $error("tck low phase");
	pins_steady_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		tck |-> $stable(tms) && $stable(tdi)) else $error("tms or tdi moved");
endmodule : bsic_link_monitor
`default_nettype wire

//--- bsic_pkg.sv
// bsic_pkg: shared constants and types for the boundary-scan instruction control
// assumes: included before the interface and both end modules
`default_nettype none
package bsic_pkg;
	localparam int IR_W = 3; // instruction register width
	localparam int BS_W = 8; // boundary register length
	localparam logic [2:0] OP_EXTEST = 3'h0;
	localparam logic [2:0] OP_SAMPLE = 3'h1;
	localparam logic [2:0] OP_USER_INSTR_ONE = 3'h2; // user_instr_one
	localparam logic [2:0] OP_USER_INSTR_TWO = 3'h3; // user_instr_two
	localparam logic [2:0] OP_CONFIG = 3'h5;
	localparam logic [2:0] OP_RDBACK = 3'h4;
	localparam logic [2:0] OP_RSVD = 3'h6;
	localparam logic [2:0] OP_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPT_FIX = 3'h1; // fixed low bits of the status word
	localparam int INIT_BIT = 0; // boundary cell that carries the init pin
	localparam int CLK_MHZ = 50; // system clock rate
	localparam int INIT_REL_US = 1000; // init release time after power-up, 1 ms
	localparam int INIT_REL_CYC = INIT_REL_US * CLK_MHZ; // cycles, exact product
	localparam int TCK_DIV = 2; // half-period of generated test clock in clk cycles
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} bsic_tap_t;
	typedef enum logic [1:0] {
		PH_PRE, PH_INTER, PH_POST
	} bsic_phase_t;
	typedef enum logic [2:0] {
		HS_IDLE, HS_LOW, HS_HIGH, HS_DONE
	} bsic_host_t;
endpackage : bsic_pkg
`default_nettype wire
